// file: hdl/vcer_pkg.sv
// Constants for the VME adapter configuration and error register bank.
// Assumes a 32-bit Avalon-MM slave port with word addressing in bytes.
package vcer_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_DEV_CFG = 4'h0;
    localparam logic [3:0] OFS_ERR_SUM = 4'h4;
    localparam logic [3:0] OFS_INT_STS = 4'h8;
    localparam logic [3:0] OFS_INT_MSK = 4'hC;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLK_SEL_LSB = 14;
    localparam int PRIO_SEL_LSB = 12;
    localparam int REV_LSB = 8;
    localparam int PAR_ERR_BIT = 31;
    localparam int BERR_BIT = 30;
    localparam int SUMMARY_BIT = 28;
    localparam int EV_PAR = 0;
    localparam int EV_BERR = 1;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CLK_SEL_RST = 2'h0;
    localparam logic [1:0] PRIO_SEL_RST = 2'h0;
    localparam logic [1:0] INT_MSK_RST = 2'h0;
    // ------------------------------------------------------------
    // Serial clock half periods in CLK cycles, per select code
    // ------------------------------------------------------------
    localparam logic [3:0] HALF_SEL0 = 4'h1;
    localparam logic [3:0] HALF_SEL1 = 4'h2;
    localparam logic [3:0] HALF_SEL2 = 4'h4;
    localparam logic [3:0] HALF_SEL3 = 4'h8;
    // ------------------------------------------------------------
    // Host request line and level bases
    // ------------------------------------------------------------
    localparam logic [2:0] REQ_LINE_BASE = 3'h4;
    localparam logic [4:0] LVL_BASE = 5'h14;
endpackage

// file: hdl/vcer_serclk.sv
// Serial clock generator for the VMEbus serial clock line.
// Assumes one system clock; the line toggles on divider enables.
`timescale 1ns/100ps
module vcer_serclk (
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [1:0] sel, // Frequency select code
    output logic serclk // Serial clock output
);
    typedef struct packed {
        logic [3:0] cnt;
        logic clk_out;
    } vcer_sc_t;
    vcer_sc_t st_reg, st_next;
    logic [3:0] half;

    // Half period chosen by select code
    always_comb begin
        unique case (sel)
            2'h0: half = vcer_pkg::HALF_SEL0;
            2'h1: half = vcer_pkg::HALF_SEL1;
            2'h2: half = vcer_pkg::HALF_SEL2;
            2'h3: half = vcer_pkg::HALF_SEL3;
        endcase
    end

    // Count to half period, then toggle the line
    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt + 4'h1 >= half) begin
            st_next.cnt = 4'h0;
            st_next.clk_out = ~st_reg.clk_out;
        end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign serclk = st_reg.clk_out;
endmodule

// file: hdl/vcer_regs.sv
// Configuration and error register bank of the VME side adapter module.
// Assumes an Avalon-MM master with waitrequest and synchronous inputs.
//
// Operation
// RQ1 - Bits 15:14 of the configuration register pick the serial clock rate, fastest at 00 and slowest at 11.
// RQ2 - The module drives the serial clock line itself at the selected rate.
// RQ3 - Bits 13:12 pick the host request line and level, line 4 level 14 at 00 up to line 7 level 17 at 11.
// RQ4 - Bits 11:8 return the jumper revision and ignore writes.
// RQ5 - Bits 7:0 always return the fixed device type code.
// RQ6 - Bit 31 of the error summary sets on a swap memory parity fault.
// RQ7 - A logged parity fault with its interrupt enabled sends an internal bus interrupt transaction.
// RQ8 - The parity flag keeps only the first fault until software writes one to clear it.
// RQ9 - Bit 30 mirrors the bus error line, one while the line is low.
// RQ10 - Writing the bus error bit lets diagnostics drive the bus error line.
// RQ11 - Bit 28 reads as the OR of all error flags including the bus error mirror.
// RQ12 - Writing zero leaves error flags unchanged and reads have no side effects.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module vcer_regs #(
    parameter logic [7:0] DEV_TYPE = 8'h5A // Device type code, value arbitrary
) (
    input wire logic CLK, // System clock, 25 MHz
    input wire logic RST_B, // Async reset, active low
    input wire logic [3:0] AVS_ADDRESS, // Byte address
    input wire logic AVS_READ, // Read request
    input wire logic AVS_WRITE, // Write request
    input wire logic [31:0] AVS_WRITEDATA, // Write data
    output logic [31:0] AVS_READDATA, // Read data
    output logic AVS_WAITREQUEST, // Stall while high
    input wire logic [3:0] REV_JUMPER, // Module revision jumpers
    input wire logic SWAP_PAR_FAULT, // Parity fault pulse on swap read
    input wire logic BERR_B_I, // Bus error line level, active low
    output logic BERR_B_O, // Bus error drive value
    output logic BERR_B_OE, // Bus error drive enable
    output logic SERCLK, // Serial clock line
    output logic IRQ, // Level interrupt output
    output logic INT_TXN, // Internal bus interrupt pulse
    output logic [2:0] INT_REQ_LINE, // Host request line number
    output logic [4:0] INT_PRIO_LEVEL // Interrupt priority level
);
    typedef struct packed {
        logic [1:0] clk_sel;
        logic [1:0] prio_sel;
        logic par_err;
        logic berr_force;
        logic berr_prev;
        logic [1:0] int_sts;
        logic [1:0] int_msk;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic int_txn;
        logic [2:0] req_line;
        logic [4:0] prio_lvl;
        logic serclk;
    } vcer_state_t;

    vcer_state_t st_reg, st_next;
    logic berr_mirror;
    logic par_log;
    logic [31:0] cfg_val;
    logic [31:0] err_val;
    logic wr_do;
    logic serclk_int;

    // ------------------------------------------------------------
    // Serial clock
    // ------------------------------------------------------------
    // RQ2 drive serial clock
    vcer_serclk u_serclk (
        .clk(CLK),
        .rst_b(RST_B),
        .sel(st_reg.clk_sel),
        .serclk(serclk_int)
    );

    // ------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------
    // RQ9 bus error mirror
    assign berr_mirror = ~BERR_B_I;
    // RQ8 log first fault only
    assign par_log = SWAP_PAR_FAULT & ~st_reg.par_err;
    // Write commits at the edge the master sees waitrequest low
    assign wr_do = AVS_WRITE & ~st_reg.waitreq;

    // Configuration and error summary read values
    always_comb begin
        cfg_val = 32'h0;
        // RQ1 clock select field
        cfg_val[vcer_pkg::CLK_SEL_LSB +: 2] = st_reg.clk_sel;
        cfg_val[vcer_pkg::PRIO_SEL_LSB +: 2] = st_reg.prio_sel;
        // RQ4 jumper revision
        cfg_val[vcer_pkg::REV_LSB +: 4] = REV_JUMPER;
        // RQ5 fixed device type
        cfg_val[7:0] = DEV_TYPE;
        err_val = 32'h0;
        err_val[vcer_pkg::PAR_ERR_BIT] = st_reg.par_err;
        err_val[vcer_pkg::BERR_BIT] = berr_mirror;
        // RQ11 error summary OR
        err_val[vcer_pkg::SUMMARY_BIT] = st_reg.par_err | berr_mirror;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.int_txn = 1'b0;
        st_next.berr_prev = berr_mirror;
        // RQ2 register serial clock line
        st_next.serclk = serclk_int;
        // Bus handshake: one wait cycle, then one answer cycle
        if ((AVS_READ | AVS_WRITE) & st_reg.waitreq) begin
            st_next.waitreq = 1'b0;
            unique case (AVS_ADDRESS)
                vcer_pkg::OFS_DEV_CFG: st_next.rdata = cfg_val;
                vcer_pkg::OFS_ERR_SUM: st_next.rdata = err_val;
                vcer_pkg::OFS_INT_STS: st_next.rdata = {30'h0, st_reg.int_sts};
                vcer_pkg::OFS_INT_MSK: st_next.rdata = {30'h0, st_reg.int_msk};
                default: st_next.rdata = 32'h0;
            endcase
        end else begin
            st_next.waitreq = 1'b1;
        end
        // RQ12 clear only on ones
        if (wr_do && AVS_ADDRESS == vcer_pkg::OFS_DEV_CFG) begin
            // RQ1 store clock select
            st_next.clk_sel = AVS_WRITEDATA[vcer_pkg::CLK_SEL_LSB +: 2];
            // RQ3 store priority select
            st_next.prio_sel = AVS_WRITEDATA[vcer_pkg::PRIO_SEL_LSB +: 2];
        end
        if (wr_do && AVS_ADDRESS == vcer_pkg::OFS_ERR_SUM) begin
            if (AVS_WRITEDATA[vcer_pkg::PAR_ERR_BIT]) begin
                st_next.par_err = 1'b0;
            end
            // RQ10 diagnostic bus error drive
            st_next.berr_force = AVS_WRITEDATA[vcer_pkg::BERR_BIT];
        end
        if (wr_do && AVS_ADDRESS == vcer_pkg::OFS_INT_STS) begin
            st_next.int_sts = st_reg.int_sts & ~AVS_WRITEDATA[1:0];
        end
        if (wr_do && AVS_ADDRESS == vcer_pkg::OFS_INT_MSK) begin
            st_next.int_msk = AVS_WRITEDATA[1:0];
        end
        // RQ6 parity fault sets flag; with the flag already set, a same-cycle clear wins and the fault is not logged
        if (par_log) begin
            st_next.par_err = 1'b1;
            st_next.int_sts[vcer_pkg::EV_PAR] = 1'b1;
            // RQ7 internal bus interrupt
            st_next.int_txn = st_reg.int_msk[vcer_pkg::EV_PAR];
        end
        // Bus error assertion event
        if (berr_mirror & ~st_reg.berr_prev) begin
            st_next.int_sts[vcer_pkg::EV_BERR] = 1'b1;
        end
        st_next.irq = |(st_next.int_sts & st_next.int_msk);
        // RQ3 request line and level
        st_next.req_line = vcer_pkg::REQ_LINE_BASE + {1'b0, st_next.prio_sel};
        st_next.prio_lvl = vcer_pkg::LVL_BASE + {3'h0, st_next.prio_sel};
    end

    // State register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= '0;
            st_reg.clk_sel <= vcer_pkg::CLK_SEL_RST;
            st_reg.prio_sel <= vcer_pkg::PRIO_SEL_RST;
            st_reg.int_msk <= vcer_pkg::INT_MSK_RST;
            st_reg.waitreq <= 1'b1;
            st_reg.req_line <= vcer_pkg::REQ_LINE_BASE;
            st_reg.prio_lvl <= vcer_pkg::LVL_BASE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign SERCLK = st_reg.serclk;
    assign AVS_READDATA = st_reg.rdata;
    assign AVS_WAITREQUEST = st_reg.waitreq;
    assign BERR_B_O = 1'b0;
    assign BERR_B_OE = st_reg.berr_force;
    assign IRQ = st_reg.irq;
    assign INT_TXN = st_reg.int_txn;
    assign INT_REQ_LINE = st_reg.req_line;
    assign INT_PRIO_LEVEL = st_reg.prio_lvl;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_clk_sel_wr;
        @(posedge CLK) disable iff (!RST_B)
        (wr_do && AVS_ADDRESS == vcer_pkg::OFS_DEV_CFG) |=>
            st_reg.clk_sel == $past(AVS_WRITEDATA[15:14]);
    endproperty
    a_clk_sel_wr: assert property (p_clk_sel_wr) else $error("clock select not stored"); // RQ1

    property p_serclk_toggle;
        @(posedge CLK) disable iff (!RST_B)
        (st_reg.clk_sel == 2'h0) [*4] |-> ($changed(serclk_int));
    endproperty
    a_serclk_toggle: assert property (p_serclk_toggle) else $error("serial clock stuck"); // RQ2

    property p_prio_map;
        @(posedge CLK) disable iff (!RST_B)
        $stable(st_reg.prio_sel) |=>
            INT_REQ_LINE == 3'h4 + {1'b0, st_reg.prio_sel} && INT_PRIO_LEVEL == 5'h14 + {3'h0, st_reg.prio_sel};
    endproperty
    a_prio_map: assert property (p_prio_map) else $error("request line or level wrong"); // RQ3

    property p_rev_read;
        @(posedge CLK) disable iff (!RST_B)
        (AVS_READ && st_reg.waitreq && AVS_ADDRESS == vcer_pkg::OFS_DEV_CFG) |=>
            AVS_READDATA[11:8] == $past(REV_JUMPER) && AVS_READDATA[7:0] == DEV_TYPE && !AVS_WAITREQUEST;
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision or type read wrong"); // RQ4

    property p_par_set;
        @(posedge CLK) disable iff (!RST_B)
        (SWAP_PAR_FAULT && !(st_reg.par_err && wr_do && AVS_ADDRESS == vcer_pkg::OFS_ERR_SUM && AVS_WRITEDATA[31]))
            |=> st_reg.par_err;
    endproperty
    a_par_set: assert property (p_par_set) else $error("parity flag not set"); // RQ6

    property p_par_txn;
        @(posedge CLK) disable iff (!RST_B)
        (par_log && st_reg.int_msk[0]) |=> INT_TXN ##1 !INT_TXN;
    endproperty
    a_par_txn: assert property (p_par_txn) else $error("interrupt transaction missing"); // RQ7

    property p_par_hold;
        @(posedge CLK) disable iff (!RST_B)
        (st_reg.par_err && !(wr_do && AVS_ADDRESS == vcer_pkg::OFS_ERR_SUM && AVS_WRITEDATA[31])) |=>
            st_reg.par_err && !INT_TXN;
    endproperty
    a_par_hold: assert property (p_par_hold) else $error("parity flag lost or relogged"); // RQ8

    property p_berr_mirror;
        @(posedge CLK) disable iff (!RST_B)
        (AVS_READ && st_reg.waitreq && AVS_ADDRESS == vcer_pkg::OFS_ERR_SUM) |=>
            AVS_READDATA[30] == !$past(BERR_B_I) && AVS_READDATA[28] == (AVS_READDATA[30] | AVS_READDATA[31]);
    endproperty
    a_berr_mirror: assert property (p_berr_mirror) else $error("bus error mirror or summary wrong"); // RQ9

    property p_berr_force;
        @(posedge CLK) disable iff (!RST_B)
        (wr_do && AVS_ADDRESS == vcer_pkg::OFS_ERR_SUM) |=> BERR_B_OE == $past(AVS_WRITEDATA[30]);
    endproperty
    a_berr_force: assert property (p_berr_force) else $error("bus error drive not taken"); // RQ10

    property p_irq_level;
        @(posedge CLK) disable iff (!RST_B)
        ##1 IRQ == |(st_reg.int_sts & st_reg.int_msk);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong"); // IRQ level, no RQ

    property p_no_clear_zero;
        @(posedge CLK) disable iff (!RST_B)
        (st_reg.par_err && !(wr_do && AVS_WRITEDATA[31])) |=> st_reg.par_err;
    endproperty
    a_no_clear_zero: assert property (p_no_clear_zero) else $error("flag cleared without a one"); // RQ12

    property p_serclk_out;
        @(posedge CLK) disable iff (!RST_B)
        ##1 SERCLK == $past(serclk_int);
    endproperty
    a_serclk_out: assert property (p_serclk_out) else $error("serial clock line not registered"); // RQ2

    property p_prio_wr;
        @(posedge CLK) disable iff (!RST_B)
        (wr_do && AVS_ADDRESS == vcer_pkg::OFS_DEV_CFG) |=>
            st_reg.prio_sel == $past(AVS_WRITEDATA[13:12]);
    endproperty
    a_prio_wr: assert property (p_prio_wr) else $error("priority select not stored"); // RQ3

    property p_rev_write;
        @(posedge CLK) disable iff (!RST_B)
        (wr_do && AVS_ADDRESS == vcer_pkg::OFS_DEV_CFG) |=>
            cfg_val[11:0] == {REV_JUMPER, DEV_TYPE};
    endproperty
    a_rev_write: assert property (p_rev_write) else $error("read-only fields changed by write"); // RQ4

    property p_txn_masked;
        @(posedge CLK) disable iff (!RST_B)
        (par_log && !st_reg.int_msk[vcer_pkg::EV_PAR]) |=> !INT_TXN;
    endproperty
    a_txn_masked: assert property (p_txn_masked) else $error("masked fault sent a transaction"); // RQ7

    property p_txn_cause;
        @(posedge CLK) disable iff (!RST_B)
        INT_TXN |-> $past(SWAP_PAR_FAULT);
    endproperty
    a_txn_cause: assert property (p_txn_cause) else $error("transaction without a fault"); // RQ7

    property p_berr_open_drain;
        @(posedge CLK) disable iff (!RST_B)
        BERR_B_OE |-> !BERR_B_O;
    endproperty
    a_berr_open_drain: assert property (p_berr_open_drain) else $error("bus error driven high"); // RQ10

    property p_read_no_side;
        @(posedge CLK) disable iff (!RST_B)
        (AVS_READ && st_reg.par_err) |=> st_reg.par_err;
    endproperty
    a_read_no_side: assert property (p_read_no_side) else $error("read disturbed the parity flag"); // RQ12
endmodule

// file: bench/vcer_vme_model.sv
// Far side of the bus error line: an open-drain wire with a pull-up.
// Assumes the adapter drives only low, gated by its enable.
`timescale 1ns/100ps
module vcer_vme_model (
    input wire logic oe, // Adapter drive enable
    input wire logic o, // Adapter drive value
    input wire logic other_berr, // Another board pulls the line
    output logic berr_b // Resolved line level
);
    // Any party pulling low wins, else the pull-up holds it high
    assign berr_b = ((oe && !o) || other_berr) ? 1'b0 : 1'b1;
endmodule

// file: bench/tb.sv
// Self-checking bench for the configuration and error register bank.
// Assumes Avalon-MM answers after one wait cycle and a pulled-up bus error line.
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] DEV_T = 8'hA7; // Device type, value arbitrary
    logic CLK, RST_B, AVS_READ, AVS_WRITE, SWAP_PAR_FAULT, ext_berr;
    logic [3:0] AVS_ADDRESS, REV_JUMPER, rev;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, q, d;
    logic AVS_WAITREQUEST, BERR_B_I, BERR_B_O, BERR_B_OE, SERCLK, IRQ, INT_TXN;
    logic [2:0] INT_REQ_LINE;
    logic [4:0] INT_PRIO_LEVEL;
    int mismatches = 0, checks_done = 0, cyc = 0, h, m_sel, m_prio;

    vcer_regs #(.DEV_TYPE(DEV_T)) dut_u (.CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .REV_JUMPER(REV_JUMPER),
        .SWAP_PAR_FAULT(SWAP_PAR_FAULT), .BERR_B_I(BERR_B_I), .BERR_B_O(BERR_B_O),
        .BERR_B_OE(BERR_B_OE), .SERCLK(SERCLK), .IRQ(IRQ), .INT_TXN(INT_TXN),
        .INT_REQ_LINE(INT_REQ_LINE), .INT_PRIO_LEVEL(INT_PRIO_LEVEL));
    vcer_vme_model vme_u (.oe(BERR_B_OE), .o(BERR_B_O), .other_berr(ext_berr), .berr_b(BERR_B_I));

    // Clock generation, 40 ns period
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    task summarize;
        $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_WRITEDATA <= wd;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0);
        chk(32'(n), 32'h2, "bus latency");
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask

    task pulse;
        @(posedge CLK);
        SWAP_PAR_FAULT <= 1'b1;
        @(posedge CLK);
        SWAP_PAR_FAULT <= 1'b0;
        #1;
    endtask

    // Length of the last complete serial clock half period
    task half(output int hp);
        logic s;
        for (int k = 0; k < 3; k++) begin
            s = SERCLK;
            hp = 0;
            do begin
                @(posedge CLK);
                #1;
                hp++;
            end while (SERCLK === s && hp < 40);
        end
    endtask

    function automatic logic [31:0] exp_cfg();
        return {16'h0, 2'(m_sel), 2'(m_prio), rev, DEV_T};
    endfunction

    initial begin
        {AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA, SWAP_PAR_FAULT, ext_berr} = '0;
        RST_B = 1'b0;
        rev = 4'h0;
        REV_JUMPER = rev;
        h = $urandom(32'hF0C0);
        repeat (16) @(posedge CLK);
        RST_B <= 1'b1;
        m_sel = 0;
        m_prio = 0;
        bus(1'b0, vcer_pkg::OFS_DEV_CFG, 32'h0, q);
        chk(q & 32'hFFFF, exp_cfg(), "cfg reset");
        chk(32'(INT_REQ_LINE), 32'h4, "line reset");
        bus(1'b0, vcer_pkg::OFS_INT_MSK, 32'h0, q);
        chk(q, 32'h0, "mask reset");
        bus(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rev = 4'($urandom);
            @(posedge CLK);
            REV_JUMPER <= rev;
            m_sel = i;
            m_prio = 3 - i;
            d = $urandom;
            d[15:12] = {2'(m_sel), 2'(m_prio)};
            bus(1'b1, vcer_pkg::OFS_DEV_CFG, d, q);
            bus(1'b0, vcer_pkg::OFS_DEV_CFG, 32'h0, q);
            chk(q & 32'hFFFF, exp_cfg(), "cfg read");
            chk(32'(INT_REQ_LINE), 32'(4 + m_prio), "req line");
            chk(32'(INT_PRIO_LEVEL), 32'(8'h14 + m_prio), "prio level");
            half(h);
            chk(32'(h), 32'(1 << m_sel), "serclk half");
        end
        $display("test config done");
        bus(1'b1, vcer_pkg::OFS_INT_MSK, 32'h3, q);
        pulse();
        chk(INT_TXN, 1'b1, "txn");
        chk(IRQ, 1'b1, "irq set");
        @(posedge CLK);
        #1;
        chk(INT_TXN, 1'b0, "txn pulse");
        pulse();
        chk(INT_TXN, 1'b0, "second fault");
        for (int k = 0; k < 2; k++) begin
            bus(1'b0, vcer_pkg::OFS_ERR_SUM, 32'h0, q);
            chk(q & 32'hD0000000, 32'h90000000, "parity flag");
            bus(1'b1, vcer_pkg::OFS_ERR_SUM, 32'h0, q);
        end
        bus(1'b1, vcer_pkg::OFS_ERR_SUM, 32'h80000000, q);
        bus(1'b0, vcer_pkg::OFS_ERR_SUM, 32'h0, q);
        chk(q & 32'hD0000000, 32'h0, "parity clear");
        bus(1'b1, vcer_pkg::OFS_INT_STS, 32'h3, q);
        @(posedge CLK);
        #1;
        chk(IRQ, 1'b0, "irq clear");
        bus(1'b1, vcer_pkg::OFS_INT_MSK, 32'h0, q);
        pulse();
        chk(INT_TXN, 1'b0, "masked txn");
        bus(1'b0, vcer_pkg::OFS_INT_STS, 32'h0, q);
        chk(q & 32'h1, 32'h1, "status logged");
        chk(IRQ, 1'b0, "irq masked");
        bus(1'b1, vcer_pkg::OFS_INT_MSK, 32'h1, q);
        @(posedge CLK);
        #1;
        chk(IRQ, 1'b1, "irq unmasked");
        bus(1'b1, vcer_pkg::OFS_ERR_SUM, 32'h80000000, q);
        $display("test parity done");
        ext_berr <= 1'b1;
        repeat (4) @(posedge CLK);
        bus(1'b0, vcer_pkg::OFS_ERR_SUM, 32'h0, q);
        chk(q & 32'hD0000000, 32'h50000000, "berr low");
        bus(1'b0, vcer_pkg::OFS_INT_STS, 32'h0, q);
        chk(q & 32'h2, 32'h2, "berr event");
        ext_berr <= 1'b0;
        repeat (4) @(posedge CLK);
        bus(1'b0, vcer_pkg::OFS_ERR_SUM, 32'h0, q);
        chk(q & 32'hD0000000, 32'h0, "berr high");
        bus(1'b1, vcer_pkg::OFS_ERR_SUM, 32'h40000000, q);
        @(posedge CLK);
        #1;
        chk({BERR_B_OE, BERR_B_I}, 2'b10, "berr drive");
        bus(1'b0, vcer_pkg::OFS_ERR_SUM, 32'h0, q);
        chk(q & 32'h40000000, 32'h40000000, "drive mirror");
        bus(1'b1, vcer_pkg::OFS_ERR_SUM, 32'h0, q);
        @(posedge CLK);
        #1;
        chk({BERR_B_OE, BERR_B_I}, 2'b01, "berr release");
        $display("test bus error done");
        summarize();
    end
endmodule
